// File: core/tpu_chan.sv
// one timer channel: capture, compare, edge and center pwm, buffered value
`timescale 1ns/10ps
`include "tpu_consts.svh"
module tpu_chan (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // timebase
  input wire logic dbg_i,
  input wire logic cen_i,
  input wire logic clk_on_i,
  input wire logic tick_i,
  input wire logic cnt_stb_i,
  input wire logic pwm_load_i,
  input wire logic [15:0] cnt_i,
  input wire logic [15:0] top_i,
  // register access
  input wire logic wr_sc_i,
  input wire logic wr_vh_i,
  input wire logic wr_vl_i,
  input wire logic rd_sc_i,
  input wire logic rd_vh_i,
  input wire logic rd_vl_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // pin and interrupt
  input wire logic pin_i,
  output logic pin_o,
  output logic oe_o,
  output logic irq_o
);
  tpu_pkg::tpu_mode_type mode;
  logic [6:2] ctl_q, ctl_d;
  logic chan_event_flag_q, chan_event_flag_d, arm_q, arm_d;
  logic [15:0] chan_compare_value_q, chan_compare_value_d;
  logic [15:0] vbuf_q, vbuf_d, vlat_q, vlat_d, vcen_q, vcen_d;
  logic vh_q, vh_d, vl_q, vl_d, vlv_q, vlv_d, prev_q, prev_d;
  logic pin_d, oe_d, irq_d, cap_ev, match, xfer, lvl, ell, elh;
  logic [15:0] src;

  assign ell = ctl_q[`TPU_CSC_EL_LO];
  assign elh = ctl_q[`TPU_CSC_EL_HI];

  always_comb begin
    if (cen_i && (elh || ell)) begin
      mode = tpu_pkg::TPU_CENTER_PWM;
    end else if (ctl_q[`TPU_CSC_MS_HI]) begin
      mode = tpu_pkg::TPU_EDGE_PWM;
    end else if (ctl_q[`TPU_CSC_MS_LO]) begin
      mode = tpu_pkg::TPU_COMPARE;
    end else begin
      mode = tpu_pkg::TPU_CAPTURE;
    end
  end

  always_comb begin
    src = chan_compare_value_q;
    ctl_d = ctl_q;
    chan_event_flag_d = chan_event_flag_q;
    arm_d = arm_q;
    chan_compare_value_d = chan_compare_value_q;
    vbuf_d = vbuf_q;
    vlat_d = vlat_q;
    vcen_d = vcen_q;
    vh_d = vh_q;
    vl_d = vl_q;
    vlv_d = vlv_q;
    prev_d = pin_i;
    rdata_o = 8'h00;
    // off selects no edge; both bits give either edge
    cap_ev = (mode == tpu_pkg::TPU_CAPTURE) &&
             ((ell && pin_i && !prev_q) || (elh && !pin_i && prev_q));
    match = cnt_stb_i && (mode != tpu_pkg::TPU_CAPTURE) &&
            (cnt_i == chan_compare_value_q);
    if (rd_sc_i && chan_event_flag_q) begin
      arm_d = 1'b1;
    end
    if (wr_sc_i) begin
      ctl_d = wdata_i[6:2];
      if (arm_q && !wdata_i[`TPU_CSC_FLAG]) begin
        chan_event_flag_d = 1'b0;
      end
      arm_d = 1'b0;
      vh_d = 1'b0;
      vl_d = 1'b0;
      vlv_d = 1'b0;
    end
    if (cap_ev || match) begin
      chan_event_flag_d = 1'b1;
      arm_d = 1'b0;
    end
    if (mode != tpu_pkg::TPU_CAPTURE) begin
      if (wr_vh_i) begin
        vbuf_d[15:8] = wdata_i;
        vh_d = 1'b1;
      end
      if (wr_vl_i) begin
        vbuf_d[7:0] = wdata_i;
        vl_d = 1'b1;
      end
    end
    xfer = vh_d && vl_d && (!clk_on_i ||
           ((mode == tpu_pkg::TPU_COMPARE) && tick_i) ||
           ((mode == tpu_pkg::TPU_EDGE_PWM || mode == tpu_pkg::TPU_CENTER_PWM) &&
            pwm_load_i));
    if (xfer) begin
      chan_compare_value_d = vbuf_d;
      vh_d = 1'b0;
      vl_d = 1'b0;
    end
    if (cap_ev) begin
      chan_compare_value_d = cnt_i;
    end
    // duty is sampled once per period so zero/nonzero swaps wait for the period edge
    if (cnt_stb_i && cnt_i == top_i) begin
      vcen_d = chan_compare_value_q;
    end
    if (rd_sc_i) begin
      rdata_o = {chan_event_flag_q, ctl_q, 2'h0};
    end else if (rd_vh_i || rd_vl_i) begin
      if (dbg_i) begin
        src = chan_compare_value_q;
      end else if (vlv_q) begin
        src = vlat_q;
        vlv_d = 1'b0;
      end else begin
        vlat_d = chan_compare_value_q;
        vlv_d = 1'b1;
      end
      rdata_o = rd_vh_i ? src[15:8] : src[7:0];
    end
    lvl = (vcen_q != 16'h0000) && !vcen_q[15] &&
          ((cnt_i < vcen_q) || (vcen_q >= top_i));
    pin_d = pin_o;
    unique case (mode)
      tpu_pkg::TPU_CAPTURE: begin
        pin_d = 1'b0;
      end
      tpu_pkg::TPU_COMPARE: begin
        if (match && elh) begin
          pin_d = ell;
        end else if (match && ell) begin
          pin_d = !pin_o;
        end
      end
      tpu_pkg::TPU_EDGE_PWM: begin
        if (cnt_stb_i && cnt_i == 16'h0000) begin
          pin_d = !ell;
        end
        if (match) begin
          pin_d = ell;
        end
      end
      tpu_pkg::TPU_CENTER_PWM: begin
        pin_d = lvl ^ ell;
      end
    endcase
    oe_d = (mode != tpu_pkg::TPU_CAPTURE) && (elh || ell);
    irq_d = chan_event_flag_d && ctl_d[`TPU_CSC_IE];
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctl_q <= `TPU_CSC_RST;
      chan_event_flag_q <= `TPU_BIT_RST;
      arm_q <= `TPU_BIT_RST;
      chan_compare_value_q <= `TPU_WORD_RST;
      vbuf_q <= `TPU_WORD_RST;
      vlat_q <= `TPU_WORD_RST;
      vcen_q <= `TPU_WORD_RST;
      vh_q <= `TPU_BIT_RST;
      vl_q <= `TPU_BIT_RST;
      vlv_q <= `TPU_BIT_RST;
      prev_q <= `TPU_BIT_RST;
      pin_o <= `TPU_BIT_RST;
      oe_o <= `TPU_BIT_RST;
      irq_o <= `TPU_BIT_RST;
    end else begin
      ctl_q <= ctl_d;
      chan_event_flag_q <= chan_event_flag_d;
      arm_q <= arm_d;
      chan_compare_value_q <= chan_compare_value_d;
      vbuf_q <= vbuf_d;
      vlat_q <= vlat_d;
      vcen_q <= vcen_d;
      vh_q <= vh_d;
      vl_q <= vl_d;
      vlv_q <= vlv_d;
      prev_q <= prev_d;
      pin_o <= pin_d;
      oe_o <= oe_d;
      irq_o <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_ic_nowrite;
    (mode == tpu_pkg::TPU_CAPTURE) && (wr_vh_i || wr_vl_i) && !cap_ev
      |=> chan_compare_value_q == $past(chan_compare_value_q);
  endproperty
  a_ic_nowrite: assert property (p_ic_nowrite) else $error("capture value written");

  property p_cap_flag;
    cap_ev |=> chan_event_flag_q && (chan_compare_value_q == $past(cnt_i));
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("capture lost");

  property p_match_flag;
    match |=> chan_event_flag_q;
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag missing");

  property p_epwm_end;
    (mode == tpu_pkg::TPU_EDGE_PWM) && match && !wr_sc_i |=> pin_o == $past(ell);
  endproperty
  a_epwm_end: assert property (p_epwm_end) else $error("duty end not at match");
endmodule : tpu_chan

// File: core/tpu_consts.svh
// offsets, field positions, reset values and counts of the timer/pwm unit
`ifndef TPU_CONSTS_SVH
`define TPU_CONSTS_SVH
`define TPU_ADR_SC 5'h00
`define TPU_ADR_CNTH 5'h01
`define TPU_ADR_CNTL 5'h02
`define TPU_ADR_MODH 5'h03
`define TPU_ADR_MODL 5'h04
`define TPU_ADR_CH0 5'h05
`define TPU_CH_STRIDE 5'h03
`define TPU_SC_OVF 7
`define TPU_SC_OIE 6
`define TPU_SC_CEN 5
`define TPU_SC_CLK_HI 4
`define TPU_SC_CLK_LO 3
`define TPU_SC_PS_HI 2
`define TPU_CSC_FLAG 7
`define TPU_CSC_IE 6
`define TPU_CSC_MS_HI 5
`define TPU_CSC_MS_LO 4
`define TPU_CSC_EL_HI 3
`define TPU_CSC_EL_LO 2
`define TPU_SC_RST 7'h00
`define TPU_CSC_RST 5'h00
`define TPU_WORD_RST 16'h0000
`define TPU_BIT_RST 1'b0
`define TPU_FREE_TOP 16'hffff
`define TPU_PS_W 7
`endif

// File: core/tpu_pkg.sv
// types shared by the timer/pwm unit
package tpu_pkg;
  typedef enum logic [3:0] {
    TPU_CAPTURE = 4'b0001,
    TPU_COMPARE = 4'b0010,
    TPU_EDGE_PWM = 4'b0100,
    TPU_CENTER_PWM = 4'b1000
  } tpu_mode_type;
endpackage : tpu_pkg

// File: core/tpu_presc.sv
// prescaler: divides the clock by 2**ps into a one-cycle counter tick
`timescale 1ns/10ps
`include "tpu_consts.svh"
module tpu_presc #(
  parameter int PW = `TPU_PS_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // control
  input wire logic run_i,
  input wire logic clr_i,
  input wire logic [2:0] ps_i,
  // tick
  output logic tick_o
);
  logic [PW-1:0] div_q;
  logic [PW-1:0] div_d;
  logic [PW-1:0] mask;
  logic tick_d;

  always_comb begin
    mask = PW'((8'h01 << ps_i) - 8'h01);
    tick_d = run_i && !clr_i && ((div_q & mask) == mask);
    div_d = div_q;
    if (clr_i) begin
      div_d = '0;
    end else if (run_i) begin
      div_d = div_q + PW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      div_q <= '0;
      tick_o <= `TPU_BIT_RST;
    end else begin
      div_q <= div_d;
      tick_o <= tick_d;
    end
  end
endmodule : tpu_presc

// File: core/tpu_top.sv
// top of the timer/pwm unit: counter, overflow flag, modulus, channel array
`timescale 1ns/10ps
`include "tpu_consts.svh"
module tpu_top #(
  parameter int NCH = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // byte register access
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // debug halt
  input wire logic background_debug_halt_i,
  // channel pins
  input wire logic [NCH-1:0] chan_pin_i,
  output logic [NCH-1:0] chan_pin_o,
  output logic [NCH-1:0] chan_oe_o,
  // interrupt requests
  output logic ovf_irq_o,
  output logic [NCH-1:0] chan_irq_o
);
  logic [6:0] sc_q;
  logic [6:0] sc_d;
  logic overflow_flag_q;
  logic overflow_flag_d;
  logic ovf_arm_q;
  logic ovf_arm_d;
  logic ovf_irq_d;
  logic [15:0] main_counter_value_q;
  logic [15:0] main_counter_value_d;
  logic count_up_q;
  logic count_up_d;
  logic cnt_stb_q;
  logic cnt_stb_d;
  logic [15:0] counter_modulus_q;
  logic [15:0] counter_modulus_d;
  logic [15:0] mod_buf_q;
  logic [15:0] mod_buf_d;
  logic mod_hi_q;
  logic mod_hi_d;
  logic mod_lo_q;
  logic mod_lo_d;
  logic [15:0] cnt_lat_q;
  logic [15:0] cnt_lat_d;
  logic cnt_lat_v_q;
  logic cnt_lat_v_d;
  logic [7:0] rdata_d;
  logic wr_sc;
  logic rd_sc;
  logic wr_cnt;
  logic rd_cnt;
  logic run;
  logic tick;
  logic tick_en;
  logic ovf_set;
  logic pwm_load;
  logic overflow_irq_enable;
  logic center_aligned_select;
  logic [1:0] clock_source_select;
  logic [15:0] top_cnt;
  logic [NCH-1:0] ch_hit;
  logic [7:0] ch_rd [NCH];

  ////////////////////////////////////////////////////////////////////////////////
  assign overflow_irq_enable = sc_q[`TPU_SC_OIE];
  assign center_aligned_select = sc_q[`TPU_SC_CEN];
  assign clock_source_select = sc_q[`TPU_SC_CLK_HI:`TPU_SC_CLK_LO];
  assign wr_sc = wr_i && (addr_i == `TPU_ADR_SC);
  assign rd_sc = rd_i && (addr_i == `TPU_ADR_SC);
  assign wr_cnt = wr_i && (addr_i == `TPU_ADR_CNTH || addr_i == `TPU_ADR_CNTL);
  assign rd_cnt = rd_i && (addr_i == `TPU_ADR_CNTH || addr_i == `TPU_ADR_CNTL);
  // the counter freezes while halted so reads there see a stable value
  assign run = (clock_source_select != 2'h0) && !background_debug_halt_i;
  assign tick_en = tick && run;
  assign top_cnt = (counter_modulus_q == 16'h0000) ? `TPU_FREE_TOP : counter_modulus_q;
  assign pwm_load = tick_en && (main_counter_value_q == top_cnt - 16'h0001) &&
                    (count_up_q || !center_aligned_select);

  tpu_presc u_presc (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .run_i(run),
    .clr_i(wr_cnt),
    .ps_i(sc_q[`TPU_SC_PS_HI:0]),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // control register and overflow flag
  always_comb begin
    sc_d = sc_q;
    overflow_flag_d = overflow_flag_q;
    ovf_arm_d = ovf_arm_q;
    if (rd_sc && overflow_flag_q) begin
      ovf_arm_d = 1'b1;
    end
    if (wr_sc) begin
      sc_d = wdata_i[6:0];
      if (ovf_arm_q && !wdata_i[`TPU_SC_OVF]) begin
        overflow_flag_d = 1'b0;
      end
      ovf_arm_d = 1'b0;
    end
    if (ovf_set) begin
      overflow_flag_d = 1'b1;
      ovf_arm_d = 1'b0;
    end
    ovf_irq_d = overflow_flag_d && sc_d[`TPU_SC_OIE];
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sc_q <= `TPU_SC_RST;
      overflow_flag_q <= `TPU_BIT_RST;
      ovf_arm_q <= `TPU_BIT_RST;
      ovf_irq_o <= `TPU_BIT_RST;
    end else begin
      sc_q <= sc_d;
      overflow_flag_q <= overflow_flag_d;
      ovf_arm_q <= ovf_arm_d;
      ovf_irq_o <= ovf_irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main counter, up or up/down
  always_comb begin
    main_counter_value_d = main_counter_value_q;
    count_up_d = count_up_q;
    ovf_set = 1'b0;
    if (wr_cnt) begin
      main_counter_value_d = 16'h0000;
      count_up_d = 1'b1;
    end else if (tick_en) begin
      if (!center_aligned_select) begin
        count_up_d = 1'b1;
        if (main_counter_value_q == top_cnt) begin
          main_counter_value_d = 16'h0000;
          ovf_set = 1'b1;
        end else begin
          main_counter_value_d = main_counter_value_q + 16'h0001;
        end
      end else if (count_up_q) begin
        if (main_counter_value_q >= top_cnt) begin
          main_counter_value_d = main_counter_value_q - 16'h0001;
          count_up_d = 1'b0;
          ovf_set = 1'b1;
        end else begin
          main_counter_value_d = main_counter_value_q + 16'h0001;
        end
      end else if (main_counter_value_q == 16'h0000) begin
        main_counter_value_d = 16'h0001;
        count_up_d = 1'b1;
      end else begin
        main_counter_value_d = main_counter_value_q - 16'h0001;
      end
    end
    cnt_stb_d = tick_en;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      main_counter_value_q <= `TPU_WORD_RST;
      count_up_q <= 1'b1;
      cnt_stb_q <= `TPU_BIT_RST;
    end else begin
      main_counter_value_q <= main_counter_value_d;
      count_up_q <= count_up_d;
      cnt_stb_q <= cnt_stb_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // modulus takes effect only once both bytes have arrived
  always_comb begin
    counter_modulus_d = counter_modulus_q;
    mod_buf_d = mod_buf_q;
    mod_hi_d = mod_hi_q;
    mod_lo_d = mod_lo_q;
    if (wr_i && addr_i == `TPU_ADR_MODH) begin
      mod_buf_d[15:8] = wdata_i;
      mod_hi_d = 1'b1;
    end
    if (wr_i && addr_i == `TPU_ADR_MODL) begin
      mod_buf_d[7:0] = wdata_i;
      mod_lo_d = 1'b1;
    end
    if (wr_sc) begin
      mod_hi_d = 1'b0;
      mod_lo_d = 1'b0;
    end
    if (mod_hi_d && mod_lo_d) begin
      counter_modulus_d = mod_buf_d;
      mod_hi_d = 1'b0;
      mod_lo_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      counter_modulus_q <= `TPU_WORD_RST;
      mod_buf_q <= `TPU_WORD_RST;
      mod_hi_q <= `TPU_BIT_RST;
      mod_lo_q <= `TPU_BIT_RST;
    end else begin
      counter_modulus_q <= counter_modulus_d;
      mod_buf_q <= mod_buf_d;
      mod_hi_q <= mod_hi_d;
      mod_lo_q <= mod_lo_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path; outside debug halt the first counter byte read snapshots the other byte
  always_comb begin
    logic [15:0] src;
    src = main_counter_value_q;
    rdata_d = 8'h00;
    cnt_lat_d = cnt_lat_q;
    cnt_lat_v_d = cnt_lat_v_q;
    if (wr_sc || wr_cnt) begin
      cnt_lat_v_d = 1'b0;
    end
    if (rd_sc) begin
      rdata_d = {overflow_flag_q, sc_q};
    end else if (rd_cnt) begin
      if (background_debug_halt_i) begin
        src = main_counter_value_q;
      end else if (cnt_lat_v_q) begin
        src = cnt_lat_q;
        cnt_lat_v_d = 1'b0;
      end else begin
        cnt_lat_d = main_counter_value_q;
        cnt_lat_v_d = 1'b1;
      end
      rdata_d = (addr_i == `TPU_ADR_CNTH) ? src[15:8] : src[7:0];
    end else if (rd_i && addr_i == `TPU_ADR_MODH) begin
      rdata_d = counter_modulus_q[15:8];
    end else if (rd_i && addr_i == `TPU_ADR_MODL) begin
      rdata_d = counter_modulus_q[7:0];
    end
    for (int n = 0; n < NCH; n++) begin
      if (ch_hit[n]) begin
        rdata_d = ch_rd[n];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
      cnt_lat_q <= `TPU_WORD_RST;
      cnt_lat_v_q <= `TPU_BIT_RST;
    end else begin
      rdata_o <= rdata_d;
      cnt_lat_q <= cnt_lat_d;
      cnt_lat_v_q <= cnt_lat_v_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  for (genvar n = 0; n < NCH; n++) begin : g_ch
    localparam logic [4:0] BASE = 5'(`TPU_ADR_CH0 + `TPU_CH_STRIDE * n);
    assign ch_hit[n] = rd_i && (addr_i >= BASE) && (addr_i <= BASE + 5'h02);
    tpu_chan u_chan (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .dbg_i(background_debug_halt_i),
      .cen_i(center_aligned_select),
      .clk_on_i(clock_source_select != 2'h0),
      .tick_i(tick_en),
      .cnt_stb_i(cnt_stb_q),
      .pwm_load_i(pwm_load),
      .cnt_i(main_counter_value_q),
      .top_i(top_cnt),
      .wr_sc_i(wr_i && addr_i == BASE),
      .wr_vh_i(wr_i && addr_i == BASE + 5'h01),
      .wr_vl_i(wr_i && addr_i == BASE + 5'h02),
      .rd_sc_i(rd_i && addr_i == BASE),
      .rd_vh_i(rd_i && addr_i == BASE + 5'h01),
      .rd_vl_i(rd_i && addr_i == BASE + 5'h02),
      .wdata_i(wdata_i),
      .rdata_o(ch_rd[n]),
      .pin_i(chan_pin_i[n]),
      .pin_o(chan_pin_o[n]),
      .oe_o(chan_oe_o[n]),
      .irq_o(chan_irq_o[n])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_sc_reset;
    $rose(nrst_i) |-> (sc_q == 7'h00) && !overflow_irq_enable && !ovf_irq_o;
  endproperty
  a_sc_reset: assert property (p_sc_reset) else $error("control not cleared");

  property p_ovf_irq;
    ovf_irq_o == (overflow_flag_q && overflow_irq_enable);
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("irq not flag and enable");

  property p_wrap;
    tick_en && !center_aligned_select && !wr_cnt && (main_counter_value_q == top_cnt)
      |=> overflow_flag_q && (main_counter_value_q == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("no overflow at wrap");

  property p_turn;
    tick_en && center_aligned_select && count_up_q && !wr_cnt &&
      (main_counter_value_q == top_cnt) |=> overflow_flag_q && !count_up_q;
  endproperty
  a_turn: assert property (p_turn) else $error("no overflow at turn");

  property p_cnt_clear;
    wr_cnt |=> (main_counter_value_q == 16'h0000) ##1 !cnt_stb_q;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared");

  sequence s_ovf_armed;
    rd_sc && overflow_flag_q;
  endsequence
  sequence s_ovf_zero;
    wr_sc && !wdata_i[`TPU_SC_OVF];
  endsequence

  // an overflow in the read cycle itself also drops the arm, so it is left out here
  property p_ovf_clear;
    (s_ovf_armed and !ovf_set) ##1 (s_ovf_zero and !ovf_set) |=> !overflow_flag_q;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("flag not cleared");

  property p_ovf_race;
    s_ovf_armed ##1 ovf_set ##1 (s_ovf_zero and !ovf_set) |=> overflow_flag_q;
  endproperty
  a_ovf_race: assert property (p_ovf_race) else $error("new overflow lost");

  property p_dbg_read;
    (rd_i && addr_i == `TPU_ADR_CNTH && background_debug_halt_i) ##1 background_debug_halt_i
      |-> rdata_o == main_counter_value_q[15:8];
  endproperty
  a_dbg_read: assert property (p_dbg_read) else $error("halted read not live");
endmodule : tpu_top

// File: tb/tb.sv
// self-checking bench of the timer/pwm unit
`timescale 1ns/10ps
`include "tpu_consts.svh"
module tb;
  logic clk_i, nrst_i, wr_i, rd_i, halt;
  logic [4:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  logic [1:0] ext, pin, pin_o, oe_o, chan_irq_o;
  logic ovf_irq_o;
  int err_total = 0;
  int num_checks = 0;
  tpu_top #(.NCH(2)) i_tpu_top (.clk_i(clk_i), .nrst_i(nrst_i), .wr_i(wr_i), .rd_i(rd_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .background_debug_halt_i(halt),
    .chan_pin_i(pin), .chan_pin_o(pin_o), .chan_oe_o(oe_o), .ovf_irq_o(ovf_irq_o),
    .chan_irq_o(chan_irq_o));
  tpu_pin_model #(.N(2)) i_tpu_pin_model (.ext_i(ext), .drv_i(pin_o), .oe_i(oe_o),
    .pin_o(pin));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 wr_i = 1'b1;
    addr_i = a;
    wdata_i = d;
    @(posedge clk_i);
    #1 wr_i = 1'b0;
  endtask : wr
  // read data is registered, so it is looked at one cycle after the strobe edge
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    #1 rd_i = 1'b1;
    addr_i = a;
    @(posedge clk_i);
    #1 rd_i = 1'b0;
    chk(rdata_o, exp);
  endtask : rd
  // bounded wait on an irq line: 0 overflow, 1+n channel n
  task automatic wait_irq(input int w);
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_i);
      #1;
      if ((w == 0 ? ovf_irq_o : chan_irq_o[w-1]) === 1'b1) return;
    end
    err_total++;
    end_of_test();
  endtask : wait_irq
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst_i = 1'b0;
    {wr_i, rd_i, halt} = 3'h0;
    addr_i = 5'h00;
    wdata_i = 8'h00;
    ext = 2'h0;
    repeat (20) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    rd(`TPU_ADR_SC, 8'h00);
    rd(5'h05, 8'h00);
    chk({oe_o, chan_irq_o, 3'h0, ovf_irq_o}, 8'h00);
    $display("test reset done");
    // capture on rising edge only, irq enabled
    wr(5'h05, 8'h44);
    ext[0] = 1'b1;
    wait_irq(1);
    rd(5'h05, 8'hc4);
    wr(5'h05, 8'h44);
    chk({7'h0, chan_irq_o[0]}, 8'h00);
    ext[0] = 1'b0;
    repeat (4) @(posedge clk_i);
    #1 chk({7'h0, chan_irq_o[0]}, 8'h00);
    wr(5'h06, 8'h12);
    wr(5'h07, 8'h34);
    rd(5'h06, 8'h00);
    rd(5'h07, 8'h00);
    $display("test capture done");
    // overflow with modulus 3
    wr(`TPU_ADR_MODH, 8'h00);
    wr(`TPU_ADR_MODL, 8'h03);
    wr(`TPU_ADR_SC, 8'h48);
    wait_irq(0);
    wr(`TPU_ADR_SC, 8'h40);
    chk({7'h0, ovf_irq_o}, 8'h01);
    rd(`TPU_ADR_SC, 8'hc0);
    wr(`TPU_ADR_SC, 8'h40);
    chk({7'h0, ovf_irq_o}, 8'h00);
    wr(`TPU_ADR_CNTH, 8'h5a);
    rd(`TPU_ADR_CNTH, 8'h00);
    rd(`TPU_ADR_CNTL, 8'h00);
    $display("test overflow done");
    // compare on channel 1, toggle on match, value 2 loaded with clock off
    wr(5'h08, 8'h54);
    wr(5'h09, 8'h00);
    wr(5'h0a, 8'h02);
    rd(5'h09, 8'h00);
    rd(5'h0a, 8'h02);
    wr(`TPU_ADR_SC, 8'h08);
    wait_irq(2);
    chk({2'h0, pin_o, chan_irq_o, oe_o}, 8'h2a);
    // same channel as edge pwm, then the whole unit in center mode
    wr(5'h08, 8'h68);
    repeat (8) @(posedge clk_i);
    wr(`TPU_ADR_SC, 8'h28);
    repeat (12) @(posedge clk_i);
    wr(`TPU_ADR_SC, 8'h00);
    $display("test compare done");
    // a control write drops the lone high modulus byte
    wr(`TPU_ADR_MODH, 8'h12);
    wr(`TPU_ADR_SC, 8'h0f);
    wr(`TPU_ADR_MODL, 8'h34);
    rd(`TPU_ADR_MODH, 8'h00);
    rd(`TPU_ADR_MODL, 8'h03);
    // divide by 128: the counter steps to 1 about 129 cycles after it is cleared
    wr(`TPU_ADR_CNTL, 8'h00);
    rd(`TPU_ADR_CNTH, 8'h00);
    repeat (140) @(posedge clk_i);
    #1 halt = 1'b1;
    // snapshot of 0 is still pending, halted reads must show the frozen 1
    rd(`TPU_ADR_CNTH, 8'h00);
    rd(`TPU_ADR_CNTL, 8'h01);
    halt = 1'b0;
    wr(`TPU_ADR_SC, 8'h00);
    $display("test debug done");
    end_of_test();
  end
endmodule : tb

// File: tb/tpu_pin_model.sv
// far side of the channel pins: an external source that loses to the unit when it drives
`timescale 1ns/10ps
module tpu_pin_model #(
  parameter int N = 2
) (
  // external source
  input wire logic [N-1:0] ext_i,
  // unit side
  input wire logic [N-1:0] drv_i,
  input wire logic [N-1:0] oe_i,
  // pin level
  output logic [N-1:0] pin_o
);
  // a released pin follows the outside source, a driven one the unit
  assign pin_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : tpu_pin_model
